/* rtl/route_cfg_defs.svh */
`ifndef ROUTE_CFG_DEFS_SVH
`define ROUTE_CFG_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_COMPONENT_LABEL 8'h6c
`define OFS_ROUTE_SELECT_ID 8'h70
`define OFS_ROUTE_EGRESS_ENTRY 8'h74
`define OFS_FALLBACK_EGRESS 8'h78
`define OFS_SWITCH_PORT_INFO 8'h14

// ****************************************
// Field positions (bit 0 is the LSB here)
// ****************************************
`define UPPER_SELECT_LSB 8
`define UPPER_SELECT_MSB 15
`define LOWER_SELECT_LSB 0
`define LOWER_SELECT_MSB 7
`define PORT_FIELD_LSB 0
`define PORT_FIELD_MSB 7

// ****************************************
// Reset values and constants
// ****************************************
`define RST_COMPONENT_LABEL 32'h0000_0000
`define RST_ROUTE_SELECT 16'h0000
`define RST_UPPER_SELECT 8'h00
`define RST_LOWER_SELECT 8'h00
`define RST_FALLBACK_EGRESS 8'hff
`define UNMAPPED_PORT 8'hff
`define ROUTE_TABLE_DEPTH 16'h01ff
`define PORT_TOTAL_DEFAULT 8'h08
`define NUM_PORTS 8
`define TABLE_ENTRIES 512

`endif

/* rtl/route_cfg_pkg.sv */
package route_cfg_pkg;

  // Avalon request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } bus_req_type;

  // Lookup result for the forwarding side
  typedef struct packed {
    logic hit;
    logic drop;
    logic [7:0] port;
  } route_result_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_TABLE_READ = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;

endpackage

/* rtl/route_table_config_regs.sv */
`timescale 1ns/1ns
// How it works
// - 32-bit writable label, reset zero, tags port-write notices.
// - Label and fallback writes reach all port copies; reads return port 0 copy.
// - Egress register accesses the table entry chosen by selector value.
// - Table writes update every port table; reads return port 0 table.
// - Selector upper byte, reset zero, gives destination identifier high byte.
// - Selector lower byte, reset zero, gives destination identifier low byte.
// - Egress low byte carries stored port number; undefined after reset.
// - Reading an unmapped entry returns 0xFF in the port field.
// - Destinations with no valid entry go to the fallback egress port.
// - Fallback resets to 0xFF; packets needing unmapped fallback are discarded.
// - Valid destination identifiers run zero to table depth 0x01FF.
`include "route_cfg_defs.svh"

module route_table_config_regs
  import route_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Switch geometry
  input wire logic [7:0] PORT_TOTAL,
  // Per-port label copies for notification tagging
  output logic [31:0] PORT_LABEL [`NUM_PORTS],
  // Forwarding lookup, one per port
  input wire logic [15:0] LOOKUP_DEST_ID [`NUM_PORTS],
  output route_result_type LOOKUP_RESULT [`NUM_PORTS]
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Above the port total means unmapped; stored as 0xFF
  function automatic logic [7:0] norm_port(input logic [7:0] p,
                                           input logic [7:0] total);
    return (p > total) ? `UNMAPPED_PORT : p;
  endfunction

  function automatic logic id_in_range(input logic [15:0] id);
    return id <= `ROUTE_TABLE_DEPTH;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0] label_value_q [`NUM_PORTS];
  logic [7:0] fallback_q [`NUM_PORTS];
  logic [7:0] upper_select_byte_q;
  logic [7:0] lower_select_byte_q;
  // Each port owns its table; broadcast writes keep them identical
  logic [7:0] table_q [`NUM_PORTS][`TABLE_ENTRIES];
  // Whole read word, captured when the request is first seen
  logic [31:0] readdata_q;
  logic [31:0] read_word;
  bus_state_type state_q;
  bus_req_type req;

  logic [15:0] sel_id;
  logic sel_valid;
  logic [8:0] sel_index;
  logic hit_label, hit_select, hit_egress, hit_fallback, hit_info;
  logic accept;

  assign req.read = AVS_READ;
  assign req.write = AVS_WRITE;
  assign req.address = AVS_ADDRESS;
  assign req.writedata = AVS_WRITEDATA;

  assign sel_id = {upper_select_byte_q, lower_select_byte_q};
  assign sel_valid = id_in_range(sel_id);
  assign sel_index = sel_id[8:0];

  assign hit_label = req.address == `OFS_COMPONENT_LABEL;
  assign hit_select = req.address == `OFS_ROUTE_SELECT_ID;
  assign hit_egress = req.address == `OFS_ROUTE_EGRESS_ENTRY;
  assign hit_fallback = req.address == `OFS_FALLBACK_EGRESS;
  assign hit_info = req.address == `OFS_SWITCH_PORT_INFO;

  // ****************************************
  // Bus sequencing
  // ****************************************
  // Reads and writes finish one cycle after the request: wait is high on
  // the first cycle, low on the second. Keeps the table read registered.
  assign accept = state_q == BUS_TABLE_READ;
  assign AVS_WAITREQUEST = (req.read | req.write) & ~accept;

  // The state walks idle, answer, recover. The recover cycle keeps a
  // request that is held across completion from being taken twice; a
  // master that releases on the answering edge never sees it.
  // Three cycles per transfer is the price of a registered read word.

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= BUS_IDLE;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (req.read | req.write) begin
            state_q <= BUS_TABLE_READ;
          end
        end
        BUS_TABLE_READ: state_q <= BUS_DONE;
        BUS_DONE: state_q <= BUS_IDLE;
        default: state_q <= BUS_IDLE;
      endcase
    end
  end

  // ****************************************
  // Label and fallback, broadcast to all ports
  // ****************************************
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        label_value_q[p] <= `RST_COMPONENT_LABEL;
      end
    end else if (accept && req.write && hit_label) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        label_value_q[p] <= merge_bytes(label_value_q[0], req.writedata,
                                        AVS_BYTEENABLE);
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        fallback_q[p] <= `RST_FALLBACK_EGRESS;
      end
    end else if (accept && req.write && hit_fallback &&
                 AVS_BYTEENABLE[0]) begin
      // Normalised at store time, so a read returns 0xFF for any
      // out-of-range value that software wrote
      for (int p = 0; p < `NUM_PORTS; p++) begin
        fallback_q[p] <= norm_port(req.writedata[7:0],
                                   PORT_TOTAL);
      end
    end
  end

  // ****************************************
  // Selector
  // ****************************************
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      upper_select_byte_q <= `RST_UPPER_SELECT;
      lower_select_byte_q <= `RST_LOWER_SELECT;
    end else if (accept && req.write && hit_select) begin
      // Each byte lane updates its own half of the selector
      if (AVS_BYTEENABLE[1]) begin
        upper_select_byte_q <=
          req.writedata[`UPPER_SELECT_MSB:`UPPER_SELECT_LSB];
      end
      if (AVS_BYTEENABLE[0]) begin
        lower_select_byte_q <=
          req.writedata[`LOWER_SELECT_MSB:`LOWER_SELECT_LSB];
      end
    end
  end

  // ****************************************
  // Route tables: no reset, contents undefined until written
  // ****************************************
  // Only an egress write touches the tables; out-of-range ids are dropped
  always_ff @(posedge CLK) begin
    if (accept && req.write && hit_egress && AVS_BYTEENABLE[0] &&
        sel_valid) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        table_q[p][sel_index] <= norm_port(req.writedata[7:0],
                                           PORT_TOTAL);
      end
    end
  end

  // ****************************************
  // Read data mux
  // ****************************************
  // Label, egress and fallback reads return the port 0 copy; the others are kept equal by
  // the broadcast writes above. Unknown offsets read as zero.
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_label) begin
      read_word = label_value_q[0];
    end else if (hit_select) begin
      read_word = {16'h0000, upper_select_byte_q, lower_select_byte_q};
    end else if (hit_egress) begin
      // Ids past the table depth have no entry and read as unmapped
      read_word = {24'h000000,
                   sel_valid ? table_q[0][sel_index]
                             : `UNMAPPED_PORT};
    end else if (hit_fallback) begin
      read_word = {24'h000000, fallback_q[0]};
    end else if (hit_info) begin
      read_word = {16'h0000, `ROUTE_TABLE_DEPTH};
    end
  end

  // Captured on the edge that first sees the read and cleared on every
  // other edge, so the word stands only in the answering cycle and the
  // bus reads zero otherwise. The table read is thus off the bus path.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      readdata_q <= 32'h0000_0000;
    end else if (state_q == BUS_IDLE && req.read) begin
      readdata_q <= read_word;
    end else begin
      readdata_q <= 32'h0000_0000;
    end
  end

  assign AVS_READDATA = readdata_q;

  // ****************************************
  // Per-port outputs
  // ****************************************
  always_comb begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      PORT_LABEL[p] = label_value_q[p];
    end
  end

  // ****************************************
  // Forwarding lookup
  // ****************************************
  // Table miss or unmapped entry falls back; unmapped fallback drops.
  // An entry never written holds an unknown value, so software must
  // fill the table (or mark entries 0xFF) before traffic starts.
  // The lookup is combinational: a port samples it with its own packet
  // header, and a table write shows on the next cycle.
  always_comb begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      LOOKUP_RESULT[p].hit = 1'b0;
      LOOKUP_RESULT[p].drop = 1'b0;
      LOOKUP_RESULT[p].port = fallback_q[p];
      if (id_in_range(LOOKUP_DEST_ID[p]) &&
          table_q[p][LOOKUP_DEST_ID[p][8:0]] <= PORT_TOTAL) begin
        LOOKUP_RESULT[p].hit = 1'b1;
        LOOKUP_RESULT[p].port = table_q[p][LOOKUP_DEST_ID[p][8:0]];
      end else if (fallback_q[p] > PORT_TOTAL) begin
        LOOKUP_RESULT[p].drop = 1'b1;
      end
    end
  end

endmodule // route_table_config_regs

/* tb/route_cfg_props.sv */
`timescale 1ns/1ns
`include "route_cfg_defs.svh"
module route_cfg_props
  import route_cfg_pkg::*;
(
  // Clock, reset and bus
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Switch side
  input wire logic [7:0] PORT_TOTAL,
  input wire logic [31:0] PORT_LABEL [`NUM_PORTS],
  input wire logic [15:0] LOOKUP_DEST_ID [`NUM_PORTS],
  input wire route_result_type LOOKUP_RESULT [`NUM_PORTS]
);
  // ****
  // Checks
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire logic done = (AVS_READ | AVS_WRITE) & !AVS_WAITREQUEST;
  wire logic rd = done & AVS_READ;
  wire logic lw = done & AVS_WRITE & (AVS_ADDRESS == 8'h6c);
  wire logic [7:0] pv = AVS_READDATA[7:0];
  sequence taken;
    (AVS_READ | AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  // Out-of-range values must read back as the unmapped code
  property rd_port(a);
    rd && AVS_ADDRESS == a |-> AVS_READDATA[31:8] == 24'h0 &&
      (pv <= PORT_TOTAL || pv == 8'hff);
  endproperty
  a_one_wait: assert property (taken |=> !AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");
  a_label_bcast: assert property (lw && AVS_BYTEENABLE == 4'hf |=>
    PORT_LABEL[0] == $past(AVS_WRITEDATA) &&
    PORT_LABEL[7] == $past(AVS_WRITEDATA))
    else $error("label write not seen on all copies");
  a_label_hold: assert property (!lw |=> $stable(PORT_LABEL[3]))
    else $error("label changed without a write");
  a_sel_read: assert property (rd && AVS_ADDRESS == 8'h70 |->
    AVS_READDATA[31:16] == 16'h0)
    else $error("selector read has upper bits set");
  a_egress_read: assert property (rd_port(8'h74))
    else $error("egress read out of range");
  a_fb_read: assert property (rd_port(8'h78))
    else $error("fallback read out of range");
  a_hit_range: assert property (LOOKUP_RESULT[0].hit |->
    LOOKUP_RESULT[0].port <= PORT_TOTAL && !LOOKUP_RESULT[0].drop)
    else $error("hit on an unmapped port");
  a_dest_range: assert property (LOOKUP_DEST_ID[1] > 16'h01ff |->
    !LOOKUP_RESULT[1].hit)
    else $error("hit beyond table depth");
endmodule // route_cfg_props

bind route_table_config_regs route_cfg_props route_cfg_props_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .PORT_TOTAL(PORT_TOTAL), .PORT_LABEL(PORT_LABEL),
  .LOOKUP_DEST_ID(LOOKUP_DEST_ID), .LOOKUP_RESULT(LOOKUP_RESULT));

/* tb/route_table_config_regs_test.sv */
`timescale 1ns/1ns
`include "route_cfg_defs.svh"
module route_table_config_regs_test
  import route_cfg_pkg::*;
;
  logic clk, rst, rd, wr, wt;
  logic [7:0] adr, ptot;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [31:0] lab [`NUM_PORTS];
  logic [15:0] dst [`NUM_PORTS];
  route_result_type res [`NUM_PORTS];
  int n_errors = 0;
  int num_checks = 0;

  route_table_config_regs route_table_config_regs_i (.CLK(clk),
    .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wt), .PORT_TOTAL(ptot), .PORT_LABEL(lab),
    .LOOKUP_DEST_ID(dst), .LOOKUP_RESULT(res));

  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge only
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wt !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) chk("waitrequest", 32'h0, 32'h1);
    q = rdat;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic w32(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic r32(string s, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask

  task conclude;
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task t_reset;
    r32("label", 8'h6c, 32'h0);
    r32("select", 8'h70, 32'h0);
    r32("fallback", 8'h78, 32'hff);
    chk("drop", 32'h1, res[1].drop);
    r32("unmapped address", 8'h40, 32'h0);
  endtask

  task t_label;
    w32(8'h6c, 32'ha5c3_0f96);
    r32("label", 8'h6c, 32'ha5c3_0f96);
    for (int i = 0; i < 8; i++) chk("copy", 32'ha5c3_0f96, lab[i]);
  endtask

  task t_table;
    dst[7] <= 16'h0103;
    w32(8'h70, 32'h0103);
    w32(8'h74, 32'h07);
    r32("entry", 8'h74, 32'h07);
    w32(8'h70, 32'h0104);
    r32("select", 8'h70, 32'h0104);
    chk("lookup port", 32'h7, res[7].port);
    chk("lookup hit", 32'h1, res[7].hit);
    w32(8'h74, 32'h08);
    r32("unmapped", 8'h74, 32'hff);
    w32(8'h74, 32'hff);
    r32("unmapped", 8'h74, 32'hff);
    chk("other entry", 32'h7, res[7].port);
  endtask

  task t_fallback;
    dst[0] <= 16'h0104;
    w32(8'h78, 32'h03);
    @(posedge clk);
    chk("fallback port", 32'h3, res[0].port);
    chk("fallback drop", 32'h0, res[0].drop);
    r32("fallback", 8'h78, 32'h03);
    w32(8'h78, 32'h09);
    r32("fallback", 8'h78, 32'hff);
    chk("drop", 32'h1, res[0].drop);
    w32(8'h70, 32'h0200);
    r32("deep entry", 8'h74, 32'hff);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    n_errors++;
    conclude;
  end

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    be = 4'hf;
    ptot = 8'h07;
    for (int i = 0; i < 8; i++) dst[i] = 16'hffff;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_label;
    t_table;
    t_fallback;
    conclude;
  end
endmodule // route_table_config_regs_test
